// File: rtl/replay_walk_event_select.sv
// Event selection registers and qualified performance counters
`timescale 1ns/1ns
`include "replay_walk_cfg.svh"

module replay_walk_event_select
  import replay_walk_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input  wire logic             clk_sys_i,
  input  wire logic             resetn_i,
  input  wire logic [7:0]       addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [31:0]      rdata_o,
  input  wire port_replay_type  store_replay_i,
  input  wire port_replay_type  load_replay_i,
  input  wire order_replay_type order_replay_i,
  input  wire walk_type         walk_i,
  input  wire lookup_type       lookup_i
);

  // ****************************************
  // Cause vectors
  // ****************************************
  logic [15:0] store_cause;
  logic [15:0] load_cause;
  logic [15:0] order_cause;
  logic [15:0] walk_cause;
  logic [15:0] lookup_cause;
  logic        lookup_read;
  logic        lookup_write;

  // Store and load port causes
  always_comb begin
    store_cause = 16'h0000;
    store_cause[`RW_BIT_DIV] = store_replay_i.divided_cause;
    load_cause = 16'h0000;
    load_cause[`RW_BIT_DIV] = load_replay_i.divided_cause;
  end

  // Ordering-buffer causes
  always_comb begin
    order_cause = 16'h0000;
    order_cause[`RW_BIT_NO_ADDR] = order_replay_i.unknown_store_address_cause;
    order_cause[`RW_BIT_NO_DATA] = order_replay_i.unknown_store_value_cause;
    order_cause[`RW_BIT_OVERLAP] = order_replay_i.overlap_mismatch_cause;
    order_cause[`RW_BIT_LOW_ADDR] = order_replay_i.low_address_mismatch_cause;
  end

  // Page-walk causes
  always_comb begin
    walk_cause = 16'h0000;
    walk_cause[`RW_BIT_DWALK] = walk_i.data_translation_miss_walk;
    walk_cause[`RW_BIT_IWALK] = walk_i.instruction_translation_miss_walk;
  end

  // ****************************************
  // Bus-unit lookup cause
  // ****************************************
  // Loads and ownership reads are reads; writebacks and evictions are writes
  always_comb begin
    lookup_read  = (lookup_i.access == ACC_LOAD) || (lookup_i.access == ACC_OWN);
    lookup_write = (lookup_i.access == ACC_WBACK) || (lookup_i.access == ACC_EVICT);
  end

  always_comb begin
    lookup_cause = 16'h0000;
    if (lookup_read) begin
      if (lookup_i.result == RES_MISS) begin
        if (lookup_i.third_level) begin
          lookup_cause[`RW_BIT_L3_MISS] = 1'b1;
        end else begin
          lookup_cause[`RW_BIT_L2_MISS] = 1'b1;
        end
      end else if (lookup_i.third_level) begin
        lookup_cause[`RW_BIT_L3_HIT + int'(lookup_i.result)] = 1'b1;
      end else begin
        lookup_cause[`RW_BIT_L2_HIT + int'(lookup_i.result)] = 1'b1;
      end
    end else if (lookup_write && !lookup_i.third_level &&
                 (lookup_i.result == RES_MISS)) begin
      lookup_cause[`RW_BIT_WR_MISS] = 1'b1;
    end
  end

  // ****************************************
  // Register port decode
  // ****************************************
  logic [2:0] reg_region;
  logic [2:0] reg_index;
  logic       word_ok;
  logic [7:0] evsel_wr;
  logic [7:0] cfg_wr;
  logic [7:0] cnt_wr;

  always_comb begin
    reg_region = addr_i[7:5];
    reg_index  = addr_i[4:2];
    word_ok    = (addr_i[1:0] == 2'b00);
  end

  // One write enable per register; misaligned or unmapped writes hit nothing
  genvar gw;
  generate
    for (gw = 0; gw < 8; gw++) begin : g_wr_dec
      logic slot_hit;

      always_comb begin
        slot_hit     = wr_i && word_ok && (reg_index == 3'(gw));
        evsel_wr[gw] = slot_hit && (reg_region == `RW_REG_EVSEL);
        cfg_wr[gw]   = slot_hit && (reg_region == `RW_REG_CFG);
        cnt_wr[gw]   = slot_hit && (reg_region == `RW_REG_COUNT);
      end
    end
  endgenerate

  // ****************************************
  // Event selection registers
  // ****************************************
  // Index 0,1: store-address unit; 2,3: ordering buffer;
  // 4,5: walk handler; 6,7: bus unit
  logic [31:0] evsel_q [8];
  logic [7:0]  evsel_hit;

  function automatic logic ev_match(input logic [31:0] sel_reg,
                                    input logic [6:0]  code,
                                    input logic        valid,
                                    input logic [15:0] cause);
    logic code_ok;
    logic mask_ok;
    code_ok  = (sel_reg[`RW_CODE_HI:`RW_CODE_LO] == code);
    mask_ok  = |(sel_reg[`RW_MASK_HI:`RW_MASK_LO] & cause);
    ev_match = valid && code_ok && mask_ok;
  endfunction : ev_match

  genvar ge;
  generate
    for (ge = 0; ge < 8; ge++) begin : g_evsel
      logic [31:0] evsel_d;

      always_comb begin
        evsel_d = evsel_q[ge];
        if (evsel_wr[ge]) begin
          evsel_d = wdata_i;
        end
      end

      always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
          evsel_q[ge] <= `RW_EVSEL_RESET;
        end else begin
          evsel_q[ge] <= evsel_d;
        end
      end

      // Each register matches only the events of its own unit
      if (ge < `RW_IDX_ORDER) begin : g_store_unit
        always_comb begin
          evsel_hit[ge] =
            ev_match(evsel_q[ge], `RW_CODE_STORE, store_replay_i.valid, store_cause) ||
            ev_match(evsel_q[ge], `RW_CODE_LOAD, load_replay_i.valid, load_cause);
        end
      end else if (ge < `RW_IDX_WALK) begin : g_order_unit
        always_comb begin
          evsel_hit[ge] = ev_match(evsel_q[ge], `RW_CODE_ORDER,
                                   order_replay_i.valid, order_cause);
        end
      end else if (ge < `RW_IDX_LOOKUP) begin : g_walk_unit
        always_comb begin
          evsel_hit[ge] = ev_match(evsel_q[ge], `RW_CODE_WALK,
                                   walk_i.valid, walk_cause);
        end
      end else begin : g_bus_unit
        always_comb begin
          evsel_hit[ge] = ev_match(evsel_q[ge], `RW_CODE_LOOKUP,
                                   lookup_i.valid, lookup_cause);
        end
      end
    end
  endgenerate

  // ****************************************
  // Counters and their configuration
  // ****************************************
  // Slot k is counter k for k < 4 and counter k + 4 otherwise
  logic [31:0]      cfg_q [8];
  logic [CNT_W-1:0] count_q [8];

  genvar gc;
  generate
    for (gc = 0; gc < 8; gc++) begin : g_cnt
      logic [31:0]      cfg_d;
      logic [CNT_W-1:0] count_d;
      logic [2:0]       sel;
      logic             enabled;
      logic             pair;
      logic             inc;

      // Bit 1 of the slot picks the first or the second selection register
      always_comb begin
        sel     = cfg_q[gc][`RW_SEL_HI:`RW_SEL_LO];
        enabled = cfg_q[gc][`RW_EN_BIT];
        pair    = 1'((gc >> 1) & 1);
      end

      if (gc < 4) begin : g_low
        logic hit_order;
        logic hit_walk;
        logic hit_lookup;

        always_comb begin
          hit_order  = (sel == `RW_SEL_ORDER) && evsel_hit[`RW_IDX_ORDER + int'(pair)];
          hit_walk   = (sel == `RW_SEL_WALK) && evsel_hit[`RW_IDX_WALK + int'(pair)];
          hit_lookup = (sel == `RW_SEL_LOOKUP) && evsel_hit[`RW_IDX_LOOKUP + int'(pair)];
          inc        = enabled && (hit_order || hit_walk || hit_lookup);
        end
      end else begin : g_high
        always_comb begin
          inc = enabled && (sel == `RW_SEL_STORE) &&
                evsel_hit[`RW_IDX_STORE + int'(pair)];
        end
      end

      always_comb begin
        cfg_d = cfg_q[gc];
        if (cfg_wr[gc]) begin
          cfg_d = wdata_i;
        end
      end

      // A software load wins over a same-cycle increment
      always_comb begin
        count_d = count_q[gc];
        if (cnt_wr[gc]) begin
          count_d = wdata_i[CNT_W-1:0];
        end else if (inc) begin
          count_d = count_q[gc] + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end

      always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
          cfg_q[gc]   <= `RW_CFG_RESET;
          count_q[gc] <= '0;
        end else begin
          cfg_q[gc]   <= cfg_d;
          count_q[gc] <= count_d;
        end
      end
    end
  endgenerate

  // ****************************************
  // Read data
  // ****************************************
  logic        rd_ok;
  logic [31:0] rd_evsel;
  logic [31:0] rd_cfg;
  logic [31:0] rd_count;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  always_comb begin
    rd_ok    = rd_i && word_ok;
    rd_evsel = evsel_q[reg_index];
    rd_cfg   = cfg_q[reg_index];
    rd_count = 32'(count_q[reg_index]);
  end

  // Zero outside a read keeps the bus quiet between accesses
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_ok) begin
      case (reg_region)
        `RW_REG_EVSEL: begin
          rdata_d = rd_evsel;
        end
        `RW_REG_CFG: begin
          rdata_d = rd_cfg;
        end
        `RW_REG_COUNT: begin
          rdata_d = rd_count;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

endmodule : replay_walk_event_select

// File: rtl/replay_walk_cfg.svh
// Constants for the replay and page-walk event selection block
// Operation
// - Store-port replays count under event code 05H in selection bits 31:25.
// - Replay cause mask bits 24:9; any selected matching cause is counted.
// - Store-port selection register 0 feeds counters 8,9; register 1 feeds 10,11.
// - Ordering-buffer load replays use event code 03H and configuration select 02H.
// - Ordering-buffer mask bit 1 selects unknown store address replays.
// - Ordering-buffer mask bit 3 selects unknown store data replays.
// - Ordering-buffer mask bit 4 selects partially overlapping load/store data replays.
// - Ordering-buffer mask bit 5 selects low four address bit mismatch replays.
// - Ordering, walk, bus-unit register 0 feeds counters 0,1; register 1 feeds 2,3.
// - Page walks use event code 01H and configuration select 04H.
// - Walk mask bit 0 selects data translation misses, bit 1 instruction misses.
// - Bus-unit counts level two and three read lookups by result, and level two write misses only.
// - Read type covers loads and ownership reads; write covers writebacks and evictions.
// - Load-port replays use event code 04H; mask bit 1 selects divided loads.
`ifndef REPLAY_WALK_CFG_SVH
`define REPLAY_WALK_CFG_SVH
// ****************************************
// Field positions
// ****************************************
`define RW_CODE_HI      31
`define RW_CODE_LO      25
`define RW_MASK_HI      24
`define RW_MASK_LO      9
`define RW_SEL_HI       15
`define RW_SEL_LO       13
`define RW_EN_BIT       12
// ****************************************
// Event codes and configuration selects
// ****************************************
`define RW_CODE_STORE   7'h05
`define RW_CODE_LOAD    7'h04
`define RW_CODE_ORDER   7'h03
`define RW_CODE_WALK    7'h01
`define RW_CODE_LOOKUP  7'h0C
`define RW_SEL_STORE    3'h2
`define RW_SEL_ORDER    3'h2
`define RW_SEL_WALK     3'h4
`define RW_SEL_LOOKUP   3'h7
// ****************************************
// Cause bit positions
// ****************************************
`define RW_BIT_DIV      1
`define RW_BIT_NO_ADDR  1
`define RW_BIT_NO_DATA  3
`define RW_BIT_OVERLAP  4
`define RW_BIT_LOW_ADDR 5
`define RW_BIT_DWALK    0
`define RW_BIT_IWALK    1
`define RW_BIT_L2_HIT   0
`define RW_BIT_L3_HIT   3
`define RW_BIT_L2_MISS  8
`define RW_BIT_L3_MISS  9
`define RW_BIT_WR_MISS  10
// ****************************************
// Register map and reset values
// ****************************************
`define RW_REG_EVSEL    3'h0
`define RW_REG_CFG      3'h1
`define RW_REG_COUNT    3'h2
`define RW_EVSEL_RESET  32'h0000_0000
`define RW_CFG_RESET    32'h0000_0000
`define RW_IDX_STORE    0
`define RW_IDX_ORDER    2
`define RW_IDX_WALK     4
`define RW_IDX_LOOKUP   6
`endif

// File: rtl/replay_walk_pkg.sv
// Types for the replay and page-walk event selection block
package replay_walk_pkg;
  typedef struct packed {
    logic valid;
    logic divided_cause;
  } port_replay_type;
  typedef struct packed {
    logic valid;
    logic unknown_store_address_cause;
    logic unknown_store_value_cause;
    logic overlap_mismatch_cause;
    logic low_address_mismatch_cause;
  } order_replay_type;
  typedef struct packed {
    logic valid;
    logic data_translation_miss_walk;
    logic instruction_translation_miss_walk;
  } walk_type;
  typedef enum logic [1:0] {
    ACC_LOAD  = 2'b00,
    ACC_OWN   = 2'b01,
    ACC_WBACK = 2'b10,
    ACC_EVICT = 2'b11
  } access_type;
  typedef enum logic [1:0] {
    RES_SHARED = 2'b00,
    RES_EXCL   = 2'b01,
    RES_MOD    = 2'b10,
    RES_MISS   = 2'b11
  } result_type;
  typedef struct packed {
    logic       valid;
    access_type access;
    logic       third_level;
    result_type result;
  } lookup_type;
endpackage : replay_walk_pkg

// File: verification/replay_walk_event_select_chk.sv
// Port-level checker for the replay and page-walk event selection block
`timescale 1ns/1ns
module replay_walk_event_select_chk
  import replay_walk_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic             clk_sys_i,
  input wire logic             resetn_i,
  input wire logic [7:0]       addr_i,
  input wire logic [31:0]      wdata_i,
  input wire logic             wr_i,
  input wire logic             rd_i,
  input wire logic [31:0]      rdata_o,
  input wire port_replay_type  store_replay_i,
  input wire port_replay_type  load_replay_i,
  input wire order_replay_type order_replay_i,
  input wire walk_type         walk_i,
  input wire lookup_type       lookup_i
);
  wire logic [4:0] ev_v;
  assign ev_v = {store_replay_i.valid, load_replay_i.valid, order_replay_i.valid, walk_i.valid, lookup_i.valid};
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  a_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  a_unmapped_read: assert property (rd_i && addr_i >= 8'h60 |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_misaligned_read: assert property (rd_i && addr_i[1:0] != 2'h0 |=> rdata_o == 32'h0)
    else $error("misaligned read not zero");
  a_select_readback: assert property (wr_i && addr_i < 8'h20 && addr_i[1:0] == 2'h0 ##1 rd_i && $stable(addr_i)
    |=> rdata_o[31:9] == $past(wdata_i[31:9], 2))
    else $error("selection register readback wrong");
  a_config_readback: assert property (wr_i && addr_i[7:5] == 3'h1 && addr_i[1:0] == 2'h0 ##1 rd_i && $stable(addr_i)
    |=> rdata_o[15:12] == $past(wdata_i[15:12], 2))
    else $error("config register readback wrong");
  a_count_readback: assert property (wr_i && addr_i[7:5] == 3'h2 && addr_i[1:0] == 2'h0 ##1 rd_i && $stable(addr_i)
    |=> rdata_o == $past(wdata_i, 2))
    else $error("counter readback wrong");
  a_count_stable: assert property (rd_i && ev_v == 5'h0 ##1 rd_i && $stable(addr_i)
    |=> rdata_o == $past(rdata_o))
    else $error("register changed without cause");
  a_count_step: assert property (rd_i && $onehot0(ev_v) ##1 rd_i && $stable(addr_i)
    |=> rdata_o - $past(rdata_o) <= 32'h1)
    else $error("counter moved by more than one");
endmodule : replay_walk_event_select_chk

bind replay_walk_event_select replay_walk_event_select_chk #(.CNT_W(CNT_W)) chk_u (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .store_replay_i(store_replay_i), .load_replay_i(load_replay_i),
  .order_replay_i(order_replay_i), .walk_i(walk_i), .lookup_i(lookup_i));

// File: verification/testbench.sv
// Self-checking testbench for the replay and page-walk event selection block
`timescale 1ns/1ns
module testbench
  import replay_walk_pkg::*;
;
  logic             clk_sys_i = 1'b0;
  logic             resetn_i = 1'b0;
  logic [7:0]       addr_i = 8'h0;
  logic [31:0]      wdata_i = 32'h0;
  logic             wr_i = 1'b0;
  logic             rd_i = 1'b0;
  logic [31:0]      rdata_o;
  port_replay_type  store_replay_i = '0;
  port_replay_type  load_replay_i = '0;
  order_replay_type order_replay_i = '0;
  walk_type         walk_i = '0;
  lookup_type       lookup_i = '0;
  logic [31:0]      v;
  logic [31:0]      v1;
  int               mismatches = 0;
  int               n_tests = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  replay_walk_event_select #(.CNT_W(32)) dut_u (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .store_replay_i(store_replay_i), .load_replay_i(load_replay_i),
    .order_replay_i(order_replay_i), .walk_i(walk_i), .lookup_i(lookup_i));
  task close_out;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  task cmp(input logic [7:0] a, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED reg %h expected %h seen %h", a, e, s);
    end
  endtask : cmp
  // Write, then read the same place back at once
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
  endtask : wr
  task chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
    cmp(a, e, v);
  endtask : chk
  // Source 0 store, 1 load, 2 ordering buffer, 3 walk, 4 lookup; held for n cycles
  task fire(input int src, input logic [4:0] c, input int n);
    @(posedge clk_sys_i);
    case (src)
      0: store_replay_i <= {1'b1, c[0]};
      1: load_replay_i <= {1'b1, c[0]};
      2: order_replay_i <= {1'b1, c[3:0]};
      3: walk_i <= {1'b1, c[1:0]};
      default: lookup_i <= {1'b1, c};
    endcase
    repeat (n) @(posedge clk_sys_i);
    store_replay_i <= '0;
    load_replay_i <= '0;
    order_replay_i <= '0;
    walk_i <= '0;
    lookup_i <= '0;
  endtask : fire
  task t_reset;
    chk(8'h00, 32'h0);
    chk(8'h20, 32'h0);
    chk(8'h40, 32'h0);
    chk(8'h60, 32'h0);
    chk(8'h41, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task t_store;
    wr(8'h00, 32'h0A00_0400);
    wr(8'h30, 32'h0000_5000);
    wr(8'h38, 32'h0000_5000);
    wr(8'h04, 32'h0800_0400);
    fire(0, 5'h1, 2);
    fire(0, 5'h0, 1);
    fire(1, 5'h1, 1);
    chk(8'h50, 32'h2);
    chk(8'h58, 32'h1);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= 8'h50;
    store_replay_i <= 2'b11;
    @(posedge clk_sys_i);
    store_replay_i <= '0;
    #1 v1 = rdata_o;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
    cmp(8'h50, 32'h2, v1);
    cmp(8'h50, 32'h3, v);
    wr(8'h51, 32'h0);
    chk(8'h50, 32'h3);
    $display("test store port done");
  endtask : t_store
  task t_order;
    logic [31:0] om [4];
    om = '{32'h400, 32'h1000, 32'h2000, 32'h4000};
    wr(8'h20, 32'h0000_5000);
    wr(8'h28, 32'h0000_5000);
    wr(8'h0C, 32'h0600_7400);
    for (int i = 0; i < 4; i++) begin
      wr(8'h08, 32'h0600_0000 | om[i]);
      wr(8'h40, 32'h0);
      for (int j = 0; j < 4; j++) fire(2, 5'(4'b1000 >> j), 1);
      chk(8'h40, 32'h1);
    end
    chk(8'h48, 32'h10);
    wr(8'h20, 32'h0000_9000);
    wr(8'h40, 32'h0);
    fire(2, 5'hF, 1);
    chk(8'h40, 32'h0);
    $display("test ordering buffer done");
  endtask : t_order
  task t_walk;
    wr(8'h10, 32'h0200_0200);
    wr(8'h24, 32'h0000_9000);
    wr(8'h44, 32'h0);
    fire(3, 5'h2, 1);
    fire(3, 5'h1, 1);
    chk(8'h44, 32'h1);
    wr(8'h10, 32'h0200_0400);
    fire(3, 5'h1, 1);
    fire(3, 5'h2, 1);
    chk(8'h44, 32'h2);
    $display("test page walk done");
  endtask : t_walk
  task t_lookup;
    logic [4:0] lk [7];
    lk = '{5'h00, 5'h08, 5'h13, 5'h1B, 5'h10, 5'h07, 5'h02};
    wr(8'h18, 32'h1808_0200);
    wr(8'h24, 32'h0000_F000);
    wr(8'h44, 32'h0);
    for (int i = 0; i < 7; i++) fire(4, lk[i], 1);
    chk(8'h44, 32'h4);
    wr(8'h18, 32'h1806_7000);
    wr(8'h44, 32'h0);
    for (int i = 0; i < 7; i++) fire(4, lk[i], 1);
    chk(8'h44, 32'h1);
    $display("test cache lookup done");
  endtask : t_lookup
  initial begin
    #100000;
    mismatches++;
    close_out;
  end
  initial begin
    repeat (12) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    t_reset;
    t_store;
    t_order;
    t_walk;
    t_lookup;
    close_out;
  end
endmodule : testbench
